/* design/ffr_defs.svh */
// Constants of the replay FIFO control block: register offsets, field positions,
// reset values and width masks. Assumes inclusion by the block.
`ifndef FFR_DEFS_SVH
`define FFR_DEFS_SVH

// Register byte offsets
`define FFR_ADDR_AE_OFS 12'h000
`define FFR_ADDR_AF_OFS 12'h004
`define FFR_ADDR_STATUS 12'h008
`define FFR_ADDR_LEVEL 12'h00c

// Offset register reset values
`define FFR_AE_OFS_RST 32'h0000_007f
`define FFR_AF_OFS_RST 32'h0000_007f

// Status field positions
`define FFR_ST_EMPTY 0
`define FFR_ST_FULL 1
`define FFR_ST_VALID 2
`define FFR_ST_SPACE 3
`define FFR_ST_AEMPTY 4
`define FFR_ST_AFULL 5
`define FFR_ST_HALF 6
`define FFR_ST_SETUP 7
`define FFR_ST_FALL 8
`define FFR_ST_STRB_WR 9
`define FFR_ST_STRB_RD 10
`define FFR_ST_ZLAT 11

// Width select codes and data masks
`define FFR_W36 2'h0
`define FFR_W18 2'h1
`define FFR_MASK36 36'hf_ffff_ffff
`define FFR_MASK18 36'h0_0003_ffff
`define FFR_MASK9 36'h0_0000_01ff

`endif

/* design/ffr_pkg.sv */
// Types shared by the replay FIFO control block.
// Assumes ffr_defs.svh is on the include path.
package ffr_pkg;

  // Strap values caught during master reset
  typedef struct packed {
    logic fall_through;
    logic async_wr;
    logic async_rd;
    logic zero_lat;
    logic [1:0] in_width;
    logic [1:0] out_width;
    logic bus_match;
    logic byte_order;
    logic flag_async;
    logic parity;
  } ffr_mode_t;

  // Replay sequencer states
  typedef enum logic [1:0] {
    FFR_RP_IDLE = 2'b01,
    FFR_RP_SETUP = 2'b10
  } ffr_rp_state_t;

endpackage

/* design/ffr_fifo_ctrl.sv */
// Replay FIFO control: storage, pointers, flags, resets, strap latching and
// replay sequencing, with an APB slave for offsets and status.
// Assumes write and read clock pins are synchronous inputs sampled on pclk.
//
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`include "ffr_defs.svh"

module ffr_fifo_ctrl #(
  parameter int DEPTH = 65536,
  parameter int DW = 36
) (
  // System
  input logic pclk,
  input logic presetn,
  // APB slave
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Resets and straps
  input logic master_reset_n,
  input logic partial_reset_n,
  input logic fallthrough_serial_in,
  input logic async_write_sel_n,
  input logic async_read_sel_n,
  input logic [1:0] out_width_sel,
  input logic [1:0] in_width_sel,
  input logic bus_match_sel,
  input logic byte_order_sel,
  input logic replay_latency_sel,
  input logic flag_timing_sel,
  input logic parity_sel,
  // Write side
  input logic wr_clk,
  input logic push_en_n,
  input logic [DW-1:0] din,
  // Read side
  input logic rd_clk,
  input logic pop_en_n,
  input logic replay_request_n,
  input logic out_en_n,
  output logic [DW-1:0] dout,
  output logic dout_oe,
  // Flags
  output logic empty_flag_n,
  output logic full_flag_n,
  output logic output_valid_n,
  output logic input_space_n,
  output logic almost_empty_n,
  output logic almost_full_n,
  output logic half_full_n
);

  localparam int AW = $clog2(DEPTH);
  localparam int PW = AW + 1;
  localparam logic [PW-1:0] DEPTH_P = PW'(DEPTH);
  localparam logic [PW-1:0] HALF_P = PW'(DEPTH / 2);
  localparam logic [PW-1:0] ONE_P = PW'(1);

  ffr_pkg::ffr_mode_t mode_q;
  ffr_pkg::ffr_rp_state_t state_q, state_d;
  logic [DW-1:0] mem [DEPTH];
  logic core_rst_n;
  logic wr_clk_q, rd_clk_q, wr_edge, rd_edge;
  logic wr_ok, start, load;
  logic [PW-1:0] wptr_q, wptr_d, rptr_q, rptr_d, cnt_q, cnt_d, load_addr;
  logic [DW-1:0] dout_q, din_m;
  logic empty_q, full_q, valid_n_q, space_n_q, ae_s1_q, ae_q, af_s1_q, af_q, hf_q;
  logic oe_q;
  logic [31:0] ae_ofs_q, af_ofs_q;
  logic pready_q, pslverr_q;
  logic [31:0] prdata_q;
  logic acc, wr_acc;

  // Either reset pin clears the data path; offsets and straps survive a partial reset
  assign core_rst_n = presetn & master_reset_n & partial_reset_n;

  // Straps are caught by a clock edge while master reset is held, never by the reset itself
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= '0;
    end else if (!master_reset_n) begin
      mode_q.fall_through <= fallthrough_serial_in;
      mode_q.async_wr <= ~async_write_sel_n;
      mode_q.async_rd <= ~async_read_sel_n;
      mode_q.zero_lat <= replay_latency_sel;
      mode_q.in_width <= in_width_sel;
      mode_q.out_width <= out_width_sel;
      mode_q.bus_match <= bus_match_sel;
      mode_q.byte_order <= byte_order_sel;
      mode_q.flag_async <= flag_timing_sel;
      mode_q.parity <= parity_sel;
    end
  end

  // Edge detect on the port clocks; inputs are already on pclk so no synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_clk_q <= 1'b0;
      rd_clk_q <= 1'b0;
    end else begin
      wr_clk_q <= wr_clk;
      rd_clk_q <= rd_clk;
    end
  end

  assign wr_edge = wr_clk & ~wr_clk_q;
  assign rd_edge = rd_clk & ~rd_clk_q;
  assign cnt_q = wptr_q - rptr_q;

  // Strobe mode ignores the enable, which the agent ties low anyway
  assign wr_ok = wr_edge & (mode_q.async_wr | ~push_en_n) & (cnt_q != DEPTH_P);
  assign start = rd_edge & ~replay_request_n & (state_q == ffr_pkg::FFR_RP_IDLE);

  // Narrow input widths use only the low lines
  always_comb begin
    unique case (mode_q.in_width)
      `FFR_W36: din_m = din & `FFR_MASK36;
      `FFR_W18: din_m = din & `FFR_MASK18;
      default: din_m = din & `FFR_MASK9;
    endcase
  end

  // Write pointer: replay never touches it
  assign wptr_d = wr_ok ? wptr_q + ONE_P : wptr_q;

  // Read side: replay sequencing and word loads into the output register
  always_comb begin
    rptr_d = rptr_q;
    state_d = state_q;
    load = 1'b0;
    load_addr = rptr_q;
    unique case (state_q)
      ffr_pkg::FFR_RP_IDLE: begin
        if (start && mode_q.zero_lat) begin
          // First word goes out on the same edge, pointer skips past it
          load = 1'b1;
          load_addr = '0;
          rptr_d = (wptr_q != '0) ? ONE_P : '0;
        end else if (start) begin
          rptr_d = '0;
          state_d = ffr_pkg::FFR_RP_SETUP;
        end else if (rd_edge && cnt_q != '0) begin
          if (mode_q.fall_through) begin
            if (valid_n_q || !pop_en_n) begin
              load = 1'b1;
              rptr_d = rptr_q + ONE_P;
            end
          end else if (mode_q.async_rd || !pop_en_n) begin
            load = 1'b1;
            rptr_d = rptr_q + ONE_P;
          end
        end
      end
      ffr_pkg::FFR_RP_SETUP: begin
        if (rd_edge) begin
          state_d = ffr_pkg::FFR_RP_IDLE;
          // Fall-through shows the first word without a pop
          if (mode_q.fall_through && wptr_q != '0) begin
            load = 1'b1;
            load_addr = '0;
            rptr_d = ONE_P;
          end
        end
      end
    endcase
  end

  assign cnt_d = wptr_d - rptr_d;

  // Storage has no reset; a partial reset simply forgets it through the pointers
  always_ff @(posedge pclk) begin
    if (wr_ok) begin
      mem[wptr_q[AW-1:0]] <= din_m;
    end
  end

  // Pointers and replay state
  always_ff @(posedge pclk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      wptr_q <= '0;
      rptr_q <= '0;
      state_q <= ffr_pkg::FFR_RP_IDLE;
    end else begin
      wptr_q <= wptr_d;
      rptr_q <= rptr_d;
      state_q <= state_d;
    end
  end

  // Output register, zeroed by either reset
  always_ff @(posedge pclk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      dout_q <= '0;
    end else if (load) begin
      dout_q <= mem[load_addr[AW-1:0]];
    end
  end

  // Empty and valid flags; in standard mode a strobe read port tracks writes every cycle
  always_ff @(posedge pclk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      empty_q <= 1'b0;
      valid_n_q <= 1'b1;
    end else if (mode_q.fall_through) begin
      if (start && !mode_q.zero_lat) begin
        valid_n_q <= 1'b1;
      end else if (load) begin
        valid_n_q <= 1'b0;
      end else if (rd_edge && !pop_en_n && state_q == ffr_pkg::FFR_RP_IDLE) begin
        valid_n_q <= 1'b1;
      end
    end else if (start && !mode_q.zero_lat) begin
      empty_q <= 1'b0;
    end else if (rd_edge || mode_q.async_rd) begin
      empty_q <= (cnt_d != '0) && (state_d == ffr_pkg::FFR_RP_IDLE);
    end
  end

  // Full and space flags; in standard mode a strobe write port tracks reads every cycle
  always_ff @(posedge pclk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      full_q <= 1'b1;
      space_n_q <= 1'b0;
    end else if (mode_q.fall_through) begin
      if (wr_edge) begin
        space_n_q <= (cnt_d == DEPTH_P);
      end
    end else if (wr_edge || mode_q.async_wr) begin
      full_q <= (cnt_d != DEPTH_P);
    end
  end

  // Half full follows the count at once, so the replay edge itself updates it
  always_ff @(posedge pclk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      hf_q <= 1'b1;
    end else begin
      hf_q <= ~(cnt_d > HALF_P);
    end
  end

  // Programmable flags: two port-clock edges in synchronous timing, the trade
  // being latency against glitch-free flags on the owning clock
  always_ff @(posedge pclk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      ae_s1_q <= 1'b0;
      ae_q <= 1'b0;
      af_s1_q <= 1'b1;
      af_q <= 1'b1;
    end else begin
      if (mode_q.flag_async) begin
        ae_q <= (cnt_d > ae_ofs_q[PW-1:0]);
        af_q <= (cnt_d < DEPTH_P - af_ofs_q[PW-1:0]);
      end else begin
        if (rd_edge) begin
          ae_s1_q <= (cnt_d > ae_ofs_q[PW-1:0]);
          ae_q <= ae_s1_q;
        end
        if (wr_edge) begin
          af_s1_q <= (cnt_d < DEPTH_P - af_ofs_q[PW-1:0]);
          af_q <= af_s1_q;
        end
      end
    end
  end

  // Output drive enable; registered, so it trails the pin by one pclk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= ~out_en_n;
    end
  end

  // APB: one wait state, answer registered
  assign acc = psel & penable & ~pready_q;
  assign wr_acc = psel & penable & pready_q & pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else begin
      pready_q <= acc;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
      if (acc) begin
        unique case (paddr)
          `FFR_ADDR_AE_OFS: prdata_q <= pwrite ? 32'h0000_0000 : ae_ofs_q;
          `FFR_ADDR_AF_OFS: prdata_q <= pwrite ? 32'h0000_0000 : af_ofs_q;
          `FFR_ADDR_STATUS: begin
            prdata_q <= '0;
            prdata_q[`FFR_ST_EMPTY] <= empty_q;
            prdata_q[`FFR_ST_FULL] <= full_q;
            prdata_q[`FFR_ST_VALID] <= valid_n_q;
            prdata_q[`FFR_ST_SPACE] <= space_n_q;
            prdata_q[`FFR_ST_AEMPTY] <= ae_q;
            prdata_q[`FFR_ST_AFULL] <= af_q;
            prdata_q[`FFR_ST_HALF] <= hf_q;
            prdata_q[`FFR_ST_SETUP] <= (state_q == ffr_pkg::FFR_RP_SETUP);
            prdata_q[`FFR_ST_FALL] <= mode_q.fall_through;
            prdata_q[`FFR_ST_STRB_WR] <= mode_q.async_wr;
            prdata_q[`FFR_ST_STRB_RD] <= mode_q.async_rd;
            prdata_q[`FFR_ST_ZLAT] <= mode_q.zero_lat;
          end
          `FFR_ADDR_LEVEL: prdata_q <= 32'(cnt_q);
          default: pslverr_q <= 1'b1;
        endcase
      end
    end
  end

  // Offset registers survive both FIFO resets; byte lanes honoured
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ae_ofs_q <= `FFR_AE_OFS_RST;
      af_ofs_q <= `FFR_AF_OFS_RST;
    end else if (wr_acc) begin
      for (int i = 0; i < 4; i++) begin
        if (pstrb[i] && paddr == `FFR_ADDR_AE_OFS) begin
          ae_ofs_q[i*8 +: 8] <= pwdata[i*8 +: 8];
        end
        if (pstrb[i] && paddr == `FFR_ADDR_AF_OFS) begin
          af_ofs_q[i*8 +: 8] <= pwdata[i*8 +: 8];
        end
      end
    end
  end

  // Outputs, all from flip-flops
  assign pready = pready_q;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;
  assign dout = dout_q;
  assign dout_oe = oe_q;
  assign empty_flag_n = empty_q;
  assign full_flag_n = full_q;
  assign output_valid_n = valid_n_q;
  assign input_space_n = space_n_q;
  assign almost_empty_n = ae_q;
  assign almost_full_n = af_q;
  assign half_full_n = hf_q;

  // Checks
  property p_std_setup;
    @(posedge pclk) disable iff (!core_rst_n)
    (start && !mode_q.fall_through && !mode_q.zero_lat) |=> (!empty_q && rptr_q == '0);
  endproperty
  a_std_setup: assert property (p_std_setup) else $error("setup not entered");

  property p_std_done;
    @(posedge pclk) disable iff (!core_rst_n)
    (state_q == ffr_pkg::FFR_RP_SETUP && rd_edge && !mode_q.fall_through)
      |=> (empty_q == (cnt_q != '0)) && state_q == ffr_pkg::FFR_RP_IDLE;
  endproperty
  a_std_done: assert property (p_std_done) else $error("setup end wrong");

  property p_fall_setup;
    @(posedge pclk) disable iff (!core_rst_n)
    (start && mode_q.fall_through && !mode_q.zero_lat)
      |=> valid_n_q ##1 (valid_n_q || rptr_q == ONE_P);
  endproperty
  a_fall_setup: assert property (p_fall_setup) else $error("valid flag in setup");

  property p_zero_lat;
    @(posedge pclk) disable iff (!core_rst_n)
    (start && mode_q.zero_lat && wptr_q != '0) |=> (rptr_q == ONE_P && state_q == ffr_pkg::FFR_RP_IDLE);
  endproperty
  a_zero_lat: assert property (p_zero_lat) else $error("zero latency load");

  property p_ae_timing;
    @(posedge pclk) disable iff (!core_rst_n)
    (!mode_q.flag_async && $past(!mode_q.flag_async) && $changed(ae_q)) |-> $past(rd_edge);
  endproperty
  a_ae_timing: assert property (p_ae_timing) else $error("almost empty off edge");

  property p_half;
    @(posedge pclk) disable iff (!core_rst_n)
    hf_q == !(cnt_q > HALF_P);
  endproperty
  a_half: assert property (p_half) else $error("half full stale");

  property p_reset_state;
    @(posedge pclk) disable iff (!presetn)
    !core_rst_n |-> (wptr_q == '0 && rptr_q == '0 && !ae_q && af_q && hf_q && dout_q == '0);
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("reset state");

  property p_straps;
    @(posedge pclk) disable iff (!presetn)
    (master_reset_n && $past(master_reset_n)) |-> $stable(mode_q);
  endproperty
  a_straps: assert property (p_straps) else $error("strap changed");

  property p_wptr_kept;
    @(posedge pclk) disable iff (!core_rst_n)
    (start && !wr_ok) |=> wptr_q == $past(wptr_q);
  endproperty
  a_wptr_kept: assert property (p_wptr_kept) else $error("replay moved wptr");

  property p_async_full;
    @(posedge pclk) disable iff (!core_rst_n)
    (mode_q.async_wr && !mode_q.fall_through && $past(mode_q.async_wr))
      |-> full_q == (cnt_q != DEPTH_P);
  endproperty
  a_async_full: assert property (p_async_full) else $error("async full stale");

endmodule

/* testbench/ffr_agent.sv */
// Partner model: the writing and reading agents in front of the replay FIFO.
// Assumes pclk from the bench; strobe edges are launched on pclk rising edges.
`timescale 1ns/100ps
module ffr_agent #(
  parameter int W = 36
) (
  // Clock
  input logic pclk,
  // Write side
  output logic wr_clk,
  output logic push_en_n,
  output logic [W-1:0] din,
  // Read side
  output logic rd_clk,
  output logic pop_en_n,
  output logic replay_request_n
);
  logic asy_w = 1'h0;
  logic asy_r = 1'h0;

  // Idle levels; strobes rest low so the first edge after reset is seen
  initial begin
    wr_clk = 1'h0;
    push_en_n = 1'h1;
    din = '0;
    rd_clk = 1'h0;
    pop_en_n = 1'h1;
    replay_request_n = 1'h1;
  end

  // One write edge; the bus shows the inverse once the word is taken
  task automatic push(input logic [W-1:0] d);
    @(posedge pclk);
    din <= d;
    push_en_n <= 1'h0;
    wr_clk <= 1'h1;
    @(posedge pclk);
    wr_clk <= 1'h0;
    push_en_n <= ~asy_w; // Stays tied low for a strobe port
    din <= ~d;
  endtask

  // One read edge, with pop and/or replay; push stays idle
  task automatic rd_edge(input logic pop, input logic rpl);
    @(posedge pclk);
    pop_en_n <= ~(pop | asy_r);
    replay_request_n <= ~rpl;
    rd_clk <= 1'h1;
    @(posedge pclk);
    rd_clk <= 1'h0;
    pop_en_n <= ~asy_r;
    replay_request_n <= 1'h1;
  endtask
endmodule

/* testbench/tb.sv */
// Bench for the replay FIFO control block: resets, straps, replay, strobe ports.
// Assumes the agent model drives the write and read sides; APB from here.
`timescale 1ns/100ps
module tb;
  localparam int DEPTH = 16;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr;
  logic [31:0] prdata, rd;
  logic er;
  logic master_reset_n = 1'h0, partial_reset_n = 1'h1, fallthrough_serial_in = 1'h0;
  logic async_write_sel_n = 1'h1, async_read_sel_n = 1'h1;
  logic [1:0] out_width_sel = 2'h0, in_width_sel = 2'h0;
  logic bus_match_sel = 1'h0, byte_order_sel = 1'h0, replay_latency_sel = 1'h0;
  logic flag_timing_sel = 1'h0, parity_sel = 1'h0, out_en_n = 1'h1;
  logic wr_clk, push_en_n, rd_clk, pop_en_n, replay_request_n, dout_oe;
  logic [35:0] din, dout;
  logic empty_flag_n, full_flag_n, output_valid_n, input_space_n;
  logic almost_empty_n, almost_full_n, half_full_n;
  logic [35:0] msk [3] = '{36'hf_ffff_ffff, 36'h0_0003_ffff, 36'h0_0000_01ff};
  int failures = 0;
  int tests_run = 0;
  wire [6:0] flags = {empty_flag_n, full_flag_n, output_valid_n, input_space_n,
                      almost_empty_n, almost_full_n, half_full_n};

  // Clock
  always #10 pclk = ~pclk;

  ffr_fifo_ctrl #(.DEPTH(DEPTH), .DW(36)) dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready,
    .prdata, .pslverr, .master_reset_n, .partial_reset_n, .fallthrough_serial_in,
    .async_write_sel_n, .async_read_sel_n, .out_width_sel, .in_width_sel,
    .bus_match_sel, .byte_order_sel, .replay_latency_sel, .flag_timing_sel,
    .parity_sel, .wr_clk, .push_en_n, .din, .rd_clk, .pop_en_n, .replay_request_n,
    .out_en_n, .dout, .dout_oe, .empty_flag_n, .full_flag_n, .output_valid_n,
    .input_space_n, .almost_empty_n, .almost_full_n, .half_full_n);

  ffr_agent #(.W(36)) ag (
    .pclk, .wr_clk, .push_en_n, .din, .rd_clk, .pop_en_n, .replay_request_n);

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [47:0] g, input logic [47:0] e);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Distinct word per position so a pointer slip shows as wrong data
  function automatic logic [35:0] wd(input int i);
    return 36'ha_5a5a_0000 + 36'(i);
  endfunction

  task automatic idle(input int k);
    repeat (k) @(posedge pclk);
    #1;
  endtask

  // APB transfer; waits for pready under a bound
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (pready !== 1'h1) begin
      failures++;
      final_report();
    end
  endtask

  task automatic pop_chk(input logic [35:0] e);
    ag.rd_edge(1'h1, 1'h0);
    idle(3);
    chk(dout, e);
  endtask

  // Master reset with straps; straps are scrambled once it is released
  task automatic mreset(input logic f, aw, ar, z, input logic [1:0] w);
    @(posedge pclk);
    master_reset_n <= 1'h0;
    fallthrough_serial_in <= f;
    async_write_sel_n <= ~aw;
    async_read_sel_n <= ~ar;
    replay_latency_sel <= z;
    in_width_sel <= w;
    out_width_sel <= w;
    ag.push_en_n <= ~aw;
    ag.pop_en_n <= ~ar;
    ag.asy_w = aw;
    ag.asy_r = ar;
    idle(3);
    chk({flags, dout}, {7'h33, 36'h0});
    @(posedge pclk);
    master_reset_n <= 1'h1;
    fallthrough_serial_in <= ~f;
    async_write_sel_n <= aw;
    async_read_sel_n <= ar;
    replay_latency_sel <= ~z;
    in_width_sel <= ~w;
    out_width_sel <= ~w;
    apb(1'h0, 12'h008, 32'h0000_0000);
    chk(rd[11:8], {z, ar, aw, f});
  endtask

  // Main sequence
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    for (int w = 0; w < 3; w++) begin
      mreset(1'h0, 1'h0, 1'h0, 1'h0, 2'(w));
      ag.push(36'hf_ffff_ffff);
      pop_chk(msk[w]);
    end
    // Standard replay with almost-empty offset of one
    mreset(1'h0, 1'h0, 1'h0, 1'h0, 2'h0);
    out_en_n <= 1'h0;
    apb(1'h1, 12'h000, 32'h0000_0001);
    for (int i = 0; i < 5; i++) ag.push(wd(i));
    for (int i = 0; i < 3; i++) ag.rd_edge(1'h1, 1'h0);
    pop_chk(wd(3));
    // Flag trails by two read edges, so one idle edge lets the low level through
    ag.rd_edge(1'h0, 1'h0);
    idle(2);
    chk({dout_oe, almost_empty_n}, 2'h2);
    ag.rd_edge(1'h0, 1'h1);
    idle(3);
    chk(empty_flag_n, 1'h0);
    apb(1'h0, 12'h00c, 32'h0000_0000);
    chk(rd, 32'h0000_0005);
    ag.rd_edge(1'h0, 1'h0);
    ag.rd_edge(1'h0, 1'h0);
    idle(3);
    chk({empty_flag_n, almost_empty_n}, 2'h3);
    for (int i = 0; i < 5; i++) pop_chk(wd(i));
    @(posedge pclk);
    out_en_n <= 1'h1;
    idle(3);
    chk(dout_oe, 1'h0);
    // Fall-through replay, then partial reset
    mreset(1'h1, 1'h0, 1'h0, 1'h0, 2'h0);
    for (int i = 0; i < 3; i++) ag.push(wd(i));
    // The first word falls through only on a read edge; no pop asked
    ag.rd_edge(1'h0, 1'h0);
    idle(3);
    chk({output_valid_n, dout}, {1'h0, wd(0)});
    pop_chk(wd(1));
    ag.rd_edge(1'h0, 1'h1);
    idle(3);
    chk(output_valid_n, 1'h1);
    ag.rd_edge(1'h0, 1'h0);
    idle(3);
    chk({output_valid_n, dout}, {1'h0, wd(0)});
    pop_chk(wd(1));
    apb(1'h1, 12'h000, 32'h0000_0005);
    @(posedge pclk);
    partial_reset_n <= 1'h0;
    idle(2);
    chk({flags, dout}, {7'h33, 36'h0});
    @(posedge pclk);
    partial_reset_n <= 1'h1;
    apb(1'h0, 12'h008, 32'h0000_0000);
    chk(rd[8], 1'h1);
    apb(1'h0, 12'h000, 32'h0000_0000);
    chk(rd, 32'h0000_0005);
    apb(1'h0, 12'h00c, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    // Zero latency replay with pop held active
    mreset(1'h0, 1'h0, 1'h0, 1'h1, 2'h0);
    for (int i = 0; i < 3; i++) ag.push(wd(i));
    pop_chk(wd(0));
    pop_chk(wd(1));
    ag.rd_edge(1'h1, 1'h1);
    idle(3);
    chk(dout, wd(0));
    pop_chk(wd(1));
    // Strobe ports: fill past full, then drain to empty
    mreset(1'h0, 1'h1, 1'h1, 1'h0, 2'h0);
    apb(1'h1, 12'h004, 32'h0000_0002);
    for (int i = 0; i < DEPTH + 1; i++) ag.push(wd(i));
    idle(3);
    chk({empty_flag_n, full_flag_n}, 2'h2);
    chk({almost_full_n, half_full_n}, 2'h0);
    apb(1'h0, 12'h00c, 32'h0000_0000);
    chk(rd, DEPTH);
    pop_chk(wd(0));
    chk(full_flag_n, 1'h1);
    for (int i = 1; i < DEPTH; i++) pop_chk(wd(i));
    chk(empty_flag_n, 1'h0);
    apb(1'h0, 12'h010, 32'h0000_0000);
    chk(er, 1'h1);
    final_report();
  end
endmodule
